// [aps_defines.svh]
// Purpose: constants for the amplifier protection sequencer
// Assumes: 40 MHz mclk
// Notes:   times kept in their own unit, cycle counts derived
`ifndef APS_DEFINES_SVH
`define APS_DEFINES_SVH

`define APS_CLK_MHZ          40
`define APS_PRECHARGE_US     1000
`define APS_PRECHARGE_CYC    (`APS_PRECHARGE_US * `APS_CLK_MHZ)
`define APS_CLIP_PULSE_NS    500
`define APS_CLIP_PULSE_CYC   ((`APS_CLIP_PULSE_NS * `APS_CLK_MHZ + 999) / 1000)
`define APS_OLP_MS           17
`define APS_OLP_FRAMES       8'd170
`define APS_INJECT_PERIOD    2'd3
`define APS_DC_CNT_MAX       8'hFF
`define APS_CNT_W            32
`define APS_ALL_HB           4'hF
`define APS_HB_AB            4'h3
`define APS_HB_CD            4'hC

`endif

// [aps_pkg.sv]
// Purpose: types for the amplifier protection sequencer
// Assumes: nothing
// Notes:   state and mode enumerations only
package aps_pkg;
  typedef enum logic [1:0] {
    APS_MODE_STEREO,
    APS_MODE_MONO_BTL,
    APS_MODE_PARALLEL,
    APS_MODE_RSVD
  } aps_mode_t;

  typedef enum logic [2:0] {
    APS_OFF,
    APS_WAIT_SUPPLY,
    APS_PRECHARGE,
    APS_RAMP_UP,
    APS_RUN,
    APS_RAMP_DOWN,
    APS_MUTED,
    APS_LOWPWR
  } aps_state_t;
endpackage

// [aps_sync3.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: asynchronous input levels
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module aps_sync3 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          level_out[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [aps_sequencer.sv]
// Purpose: startup/shutdown sequencing and protection of a two-channel
//          class-D output stage
// Assumes: analog detectors arrive as asynchronous levels; frame_start is
//          a one-cycle pulse from the PWM reference on mclk
// Notes:   bridge index 0..3 is half-bridge A..D; channel 0 = A+B
//
// Overview of operation
// - three output configurations: stereo bridged, single bridged, paralleled mono.
// - outputs high-impedance with weak pull-down until gate, analog and power-stage supplies good and pre-charge done.
// - on reset release, error low and analog regulator on until supply good.
// - after pre-charge interval, ramp up; done when soft-mute node fully charged.
// - ramps last about 20 ms with 33 nF; capacitor sets the length.
// - reset low ramps down, then outputs high-impedance, then low-power state.
// - reset low enables weak pull-downs in bridged and paralleled modes.
// - reset low forces the error indicator inactive regardless of faults.
// - soft-mute low ramps down, outputs high-impedance, internals stay powered.
// - fault puts power stage high-impedance and error indicator low at once.
// - faults self-recover except overload and overtemperature, latched until reset.
// - bridged: A/B error stops A+B, C/D stops C+D; paralleled stops all.
// - bootstrap undervoltage stops only its half-bridge, no latch, no error.
// - current limited every switching cycle, separately per full-bridge.
// - limit trip flips the full-bridge state, cleared at next frame start.
// - persisting limited overcurrent latches the channel off until reset.
// - while clipping or limiting, inject narrow pulse every fourth frame.
// - clipping shown as active-low pulses about 500 ns on thermal/clip pin.
// - current imbalance above threshold counts up; at maximum channel shuts down.
// - thermal/clip indicator low while temperature above warning level.
// - above shutdown temperature all outputs off, error asserted, latched to reset.
`timescale 1ns/100ps
`default_nettype none
`include "aps_defines.svh"
module aps_sequencer
  import aps_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       reset_pin_n,
  input  wire logic       soft_mute_n,
  input  wire logic [1:0] mode_sel,
  input  wire logic       gate_drive_supply_ok,
  input  wire logic       analog_supply_ok,
  input  wire logic       power_stage_supply_ok,
  input  wire logic       mute_node_charged,
  input  wire logic       mute_node_discharged,
  input  wire logic [1:0] cycle_current_limit,
  input  wire logic [1:0] clip_detect,
  input  wire logic [1:0] dc_imbalance,
  input  wire logic [3:0] bootstrap_undervolt,
  input  wire logic       temp_warn,
  input  wire logic       temp_shutdown,
  input  wire logic       frame_start,
  output logic [3:0]      hb_enable,
  output logic [3:0]      hb_pulldown,
  output logic [1:0]      fb_flip,
  output logic [1:0]      pulse_inject,
  output logic            mute_charge,
  output logic            mute_discharge,
  output logic            analog_reg_en,
  output logic            low_power,
  output logic            fault_n_o,
  output logic            fault_n_oe,
  output logic            thermal_clip_warn_n_o,
  output logic            thermal_clip_warn_n_oe,
  output logic            thermal_shutdown,
  output logic            supply_undervolt
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  localparam int NS = 21;
  logic [NS-1:0] raw_in;
  logic [NS-1:0] syn;
  assign raw_in = {reset_pin_n, soft_mute_n, gate_drive_supply_ok, analog_supply_ok,
                   power_stage_supply_ok, mute_node_charged, mute_node_discharged,
                   cycle_current_limit, clip_detect, dc_imbalance,
                   bootstrap_undervolt, temp_warn, temp_shutdown, mode_sel};

  aps_sync3 #(.W(NS)) u_sync (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .pin_in    (raw_in),
    .level_out (syn)
  );

  logic       rst_n_s, mute_n_s, gate_drive_supply_s, analog_supply_s, power_stage_supply_s, chg_s, dis_s;
  logic [1:0] ocl_s, clip_s, dc_s, mode_s;
  logic [3:0] bst_s;
  logic       tw_s, ts_s;
  assign {rst_n_s, mute_n_s, gate_drive_supply_s, analog_supply_s, power_stage_supply_s, chg_s, dis_s,
          ocl_s, clip_s, dc_s, bst_s, tw_s, ts_s, mode_s} = syn;

  aps_mode_t mode;
  assign mode = aps_mode_t'(mode_s);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // channel to half-bridge mask; paralleled mode widens any channel to all
  function automatic logic [3:0] chan_mask(input logic [1:0] ch, input aps_mode_t m);
    logic [3:0] r;
    r = '0;
    if (m == APS_MODE_PARALLEL && ch != 2'b00) begin
      r = `APS_ALL_HB;
    end else begin
      if (ch[0]) r = r | `APS_HB_AB;
      if (ch[1]) r = r | `APS_HB_CD;
    end
    return r;
  endfunction

  // configured active half-bridges
  function automatic logic [3:0] mode_mask(input aps_mode_t m);
    case (m)
      APS_MODE_MONO_BTL: return `APS_HB_AB;
      default:           return `APS_ALL_HB;
    endcase
  endfunction

  logic rst_prev_r;
  logic rst_rise;
  always_ff @(posedge mclk) begin
    if (sys_rst) rst_prev_r <= 1'b0;
    else         rst_prev_r <= rst_n_s;
  end
  assign rst_rise = rst_n_s & ~rst_prev_r;

  // ---------------------------------------------------------------
  // latched faults: overtemperature, overload, dc imbalance
  // ---------------------------------------------------------------
  logic       ote_r;
  logic [1:0] olp_r;
  logic [7:0] olp_cnt_r [2];
  logic [7:0] dc_cnt_r  [2];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ote_r <= 1'b0;
    end else if (ts_s) begin
      ote_r <= 1'b1;
    end else if (!rst_n_s) begin
      ote_r <= 1'b0;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      // overload = limiting for many consecutive frames
      always_ff @(posedge mclk) begin
        if (sys_rst || !rst_n_s) begin
          olp_cnt_r[c] <= '0;
        end else if (!ocl_s[c]) begin
          olp_cnt_r[c] <= '0;
        end else if (frame_start && olp_cnt_r[c] != `APS_OLP_FRAMES) begin
          olp_cnt_r[c] <= olp_cnt_r[c] + 8'h01;
        end
      end
      // imbalance counter saturates; never decrements so it is a true overload
      always_ff @(posedge mclk) begin
        if (sys_rst || !rst_n_s) begin
          dc_cnt_r[c] <= '0;
        end else if (dc_s[c] && frame_start && dc_cnt_r[c] != `APS_DC_CNT_MAX) begin
          dc_cnt_r[c] <= dc_cnt_r[c] + 8'h01;
        end
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          olp_r[c] <= 1'b0;
        end else if (olp_cnt_r[c] == `APS_OLP_FRAMES
                     || dc_cnt_r[c] == `APS_DC_CNT_MAX) begin
          olp_r[c] <= 1'b1;
        end else if (!rst_n_s) begin
          olp_r[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  aps_state_t state_r;
  logic [`APS_CNT_W-1:0] pre_cnt_r;
  logic supply_ok;
  logic uv_fault;
  assign supply_ok = gate_drive_supply_s & analog_supply_s & power_stage_supply_s;
  assign uv_fault  = ~supply_ok;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= APS_OFF;
    end else begin
      case (state_r)
        APS_OFF: begin
          if (rst_rise) state_r <= APS_WAIT_SUPPLY;
        end
        APS_WAIT_SUPPLY: begin
          if (!rst_n_s)       state_r <= APS_LOWPWR;
          else if (supply_ok) state_r <= APS_PRECHARGE;
        end
        APS_PRECHARGE: begin
          if (!rst_n_s) state_r <= APS_RAMP_DOWN;
          else if (pre_cnt_r == `APS_CNT_W'(`APS_PRECHARGE_CYC - 1))
            state_r <= APS_RAMP_UP;
        end
        APS_RAMP_UP: begin
          if (!rst_n_s || !mute_n_s) state_r <= APS_RAMP_DOWN;
          else if (chg_s)            state_r <= APS_RUN;
        end
        APS_RUN: begin
          if (!rst_n_s || !mute_n_s) state_r <= APS_RAMP_DOWN;
        end
        APS_RAMP_DOWN: begin
          if (dis_s) state_r <= rst_n_s ? APS_MUTED : APS_LOWPWR;
        end
        APS_MUTED: begin
          if (!rst_n_s)     state_r <= APS_LOWPWR;
          else if (mute_n_s) state_r <= APS_RAMP_UP;
        end
        APS_LOWPWR: begin
          if (rst_rise) state_r <= APS_WAIT_SUPPLY;
        end
        default: state_r <= APS_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state_r != APS_PRECHARGE) pre_cnt_r <= '0;
    else                                     pre_cnt_r <= pre_cnt_r + 1'b1;
  end

  // ---------------------------------------------------------------
  // half-bridge enable and pull-down
  // ---------------------------------------------------------------
  logic switching;
  logic [3:0] stop_mask;
  logic [3:0] hb_en_nxt;
  assign switching = (state_r == APS_RAMP_UP) || (state_r == APS_RUN)
                     || (state_r == APS_RAMP_DOWN);

  always_comb begin
    stop_mask = chan_mask(olp_r, mode) | bst_s;
    if (ote_r || uv_fault) stop_mask = `APS_ALL_HB;
    hb_en_nxt = switching ? (mode_mask(mode) & ~stop_mask) : 4'h0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hb_enable   <= 4'h0;
      hb_pulldown <= 4'h0;
    end else begin
      hb_enable   <= hb_en_nxt;
      // weak pull-down while reset is low, waiting for supply or pre-charging
      hb_pulldown <= (!rst_n_s || state_r == APS_WAIT_SUPPLY
                      || state_r == APS_PRECHARGE) ? `APS_ALL_HB : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // cycle current limit flip and pulse injection
  // ---------------------------------------------------------------
  logic [1:0] frame_cnt_r;
  always_ff @(posedge mclk) begin
    if (sys_rst)          frame_cnt_r <= 2'h0;
    else if (frame_start) frame_cnt_r <= frame_cnt_r + 2'h1;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fb_flip      <= 2'h0;
      pulse_inject <= 2'h0;
    end else begin
      // a trip in the frame-start cycle still flips: set beats clear
      fb_flip <= (frame_start ? 2'h0 : fb_flip) | (ocl_s & {2{switching}});
      pulse_inject <= (frame_start && frame_cnt_r == `APS_INJECT_PERIOD)
                      ? ((clip_s | ocl_s) & {2{switching}}) : 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // indicators and supply control
  // ---------------------------------------------------------------
  logic [7:0] clip_cnt_r;
  logic       clip_prev_r;
  logic       clip_any;
  assign clip_any = |clip_s;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clip_cnt_r  <= 8'h00;
      clip_prev_r <= 1'b0;
    end else begin
      clip_prev_r <= clip_any;
      if (clip_any && !clip_prev_r) clip_cnt_r <= 8'(`APS_CLIP_PULSE_CYC);
      else if (clip_cnt_r != 8'h00) clip_cnt_r <= clip_cnt_r - 8'h01;
    end
  end

  logic fault_active;
  assign fault_active = ote_r | (|olp_r) | uv_fault;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fault_n_oe             <= 1'b0;
      thermal_clip_warn_n_oe <= 1'b0;
      analog_reg_en          <= 1'b0;
      low_power              <= 1'b1;
      mute_charge            <= 1'b0;
      mute_discharge         <= 1'b0;
      thermal_shutdown       <= 1'b0;
      supply_undervolt       <= 1'b0;
    end else begin
      // reset low always releases the error pin
      fault_n_oe <= rst_n_s && (fault_active || state_r == APS_WAIT_SUPPLY);
      // clipping reports once per onset, not while level stays high: one pulse per rising edge
      thermal_clip_warn_n_oe <= tw_s || (clip_cnt_r != 8'h00);
      analog_reg_en    <= rst_n_s || (state_r != APS_OFF && state_r != APS_LOWPWR);
      low_power        <= (state_r == APS_OFF) || (state_r == APS_LOWPWR);
      mute_charge      <= (state_r == APS_RAMP_UP);
      mute_discharge   <= (state_r == APS_RAMP_DOWN);
      thermal_shutdown <= ote_r;
      supply_undervolt <= uv_fault;
    end
  end

  assign fault_n_o             = 1'b0;
  assign thermal_clip_warn_n_o = 1'b0;

endmodule
`default_nettype wire

// [aps_sequencer_assertions.sv]
// Purpose: port checks for the amplifier protection sequencer
// Assumes: single mclk domain, sync reset sys_rst
// Notes:   pin inputs pass a 3-4 cycle synchroniser before acting
`timescale 1ns/100ps
`default_nettype none
module aps_seq_chk (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       reset_pin_n,
  input wire logic       soft_mute_n,
  input wire logic [1:0] cycle_current_limit,
  input wire logic [3:0] bootstrap_undervolt,
  input wire logic       temp_warn,
  input wire logic       temp_shutdown,
  input wire logic       frame_start,
  input wire logic [3:0] hb_enable,
  input wire logic [3:0] hb_pulldown,
  input wire logic [1:0] fb_flip,
  input wire logic       mute_discharge,
  input wire logic       low_power,
  input wire logic       fault_n_oe,
  input wire logic       thermal_clip_warn_n_oe,
  input wire logic       thermal_shutdown
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // relations at the ports
  // ------------------------------
  a_fault_forced_off: assert property ((!reset_pin_n) [*6] |-> !fault_n_oe)
    else $error("fault pin driven while reset pin low");
  a_boot_uv_local: assert property ($stable(bootstrap_undervolt) [*6]
    |-> (bootstrap_undervolt & hb_enable) == 4'h0)
    else $error("half-bridge enabled under bootstrap undervoltage");
  a_thermal_stop: assert property ((temp_shutdown && reset_pin_n) [*6]
    |-> hb_enable == 4'h0 && fault_n_oe)
    else $error("thermal shutdown left outputs on or fault released");
  a_thermal_held: assert property ($fell(temp_shutdown) && reset_pin_n
    |-> thermal_shutdown [*8])
    else $error("thermal shutdown latch dropped");
  a_warn_level: assert property (temp_warn [*6] |-> thermal_clip_warn_n_oe)
    else $error("warning pin not driven while hot");
  a_pulldown_reset: assert property ((low_power && !reset_pin_n) [*3]
    |-> hb_pulldown == 4'hF)
    else $error("pull-downs off while reset pin low");
  a_low_power_hiz: assert property (low_power |-> hb_enable == 4'h0)
    else $error("switching in low power state");
  a_mute_ramp: assert property ($fell(soft_mute_n) && reset_pin_n && hb_enable != 4'h0
    |-> ##[2:8] mute_discharge)
    else $error("no ramp down after mute");
  a_flip_clear: assert property ((!cycle_current_limit[0]) [*6] ##1 frame_start
    |=> !fb_flip[0])
    else $error("flip not cleared at frame start");
  a_clip_width: assert property ($rose(thermal_clip_warn_n_oe) && !temp_warn
    |-> thermal_clip_warn_n_oe [*8])
    else $error("clip pulse too short");
endmodule

bind aps_sequencer aps_seq_chk i_aps_seq_chk (.*);
`default_nettype wire

// [aps_host_model.sv]
// Purpose: system controller and soft-mute capacitor beside the sequencer
// Assumes: behavioural, clocked by mclk
// Notes:   HOLD_CYC stands for the scaled post-fault wait
`timescale 1ns/100ps
`default_nettype none
module aps_host_model #(
  parameter int HOLD_CYC = 100,
  parameter int RAMP_CYC = 200
) (
  input  wire logic mclk,
  input  wire logic run_req,
  input  wire logic mute_req,
  input  wire logic power_ok,
  input  wire logic fault_n_oe,
  input  wire logic warn_oe,
  input  wire logic mute_charge,
  input  wire logic mute_discharge,
  output logic      reset_pin_n,
  output logic      soft_mute_n,
  output logic      fault_line,
  output logic      warn_line,
  output logic      mute_node_charged,
  output logic      mute_node_discharged
);
  int   since_fault = HOLD_CYC;
  int   node_lvl    = 0;
  logic fault_d     = 1'b1;
  // ------------------------------
  // pins with pull-ups
  // ------------------------------
  assign fault_line  = !fault_n_oe;
  assign warn_line   = !warn_oe;
  assign soft_mute_n = !mute_req; // open drain, released when idle
  assign mute_node_charged    = node_lvl == RAMP_CYC;
  assign mute_node_discharged = node_lvl == 0;
  initial reset_pin_n = 1'b0;
  always @(posedge mclk) begin
    fault_d <= fault_line;
    if (fault_d && !fault_line) since_fault <= 0;
    else if (since_fault < HOLD_CYC) since_fault <= since_fault + 1;
    // no release before supply is good or soon after a fault
    if (!run_req) reset_pin_n <= 1'b0;
    else if (power_ok && since_fault >= HOLD_CYC) reset_pin_n <= 1'b1;
  end
  // capacitor size fixes ramp length
  always @(posedge mclk) begin
    if (mute_charge && node_lvl < RAMP_CYC) node_lvl <= node_lvl + 1;
    else if (mute_discharge && node_lvl > 0) node_lvl <= node_lvl - 1;
  end
endmodule
`default_nettype wire

// [tb_aps_sequencer.sv]
// Purpose: self-checking bench for the protection sequencer
// Assumes: 40 MHz mclk, frame pulse every FRAME cycles
// Notes:   two full startups, so the run is about 90k cycles
`timescale 1ns/100ps
`default_nettype none
module tb_aps_sequencer;
  import aps_pkg::*;
  localparam int FRAME = 16;
  localparam int RAMP  = 200;
  logic       mclk = 1'b0, sys_rst = 1'b1, run_req = 1'b0, mute_req = 1'b0;
  logic       reset_pin_n, soft_mute_n, fault_line, warn_line;
  logic       mute_node_charged, mute_node_discharged;
  logic [1:0] mode_sel = 2'h0, cycle_current_limit = 2'h0, clip_detect = 2'h0;
  logic [1:0] dc_imbalance = 2'h0;
  logic       gate_drive_supply_ok = 1'b0, analog_supply_ok = 1'b0;
  logic       power_stage_supply_ok = 1'b0, temp_warn = 1'b0, temp_shutdown = 1'b0;
  logic [3:0] bootstrap_undervolt = 4'h0, hb_enable, hb_pulldown;
  logic       frame_start = 1'b0, mute_charge, mute_discharge, analog_reg_en, low_power;
  logic [1:0] fb_flip, pulse_inject;
  logic       fault_n_o, fault_n_oe, thermal_clip_warn_n_o, thermal_clip_warn_n_oe;
  logic       thermal_shutdown, supply_undervolt;
  int         n_mismatch = 0, check_count = 0, cycles = 0, fcnt = 0, n;

  always #12.5 mclk = ~mclk;
  aps_sequencer i_aps_sequencer (.*);
  aps_host_model #(.HOLD_CYC(100), .RAMP_CYC(RAMP)) i_aps_host_model (
    .mclk, .run_req, .mute_req, .power_ok(power_stage_supply_ok), .fault_n_oe,
    .warn_oe(thermal_clip_warn_n_oe), .mute_charge, .mute_discharge, .reset_pin_n,
    .soft_mute_n, .fault_line, .warn_line, .mute_node_charged, .mute_node_discharged);
  // ------------------------------
  // frame pulses and hang guard
  // ------------------------------
  always @(posedge mclk) begin
    fcnt <= (fcnt + 1) % FRAME;
    frame_start <= fcnt == FRAME - 1;
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_mismatch = n_mismatch + 1;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // results read mid-cycle, after register updates settle
  task automatic look(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_startup;
    cyc(1);
    gate_drive_supply_ok <= 1'b1;
    power_stage_supply_ok <= 1'b1;
    run_req <= 1'b1;
    look(12);
    chk("fault held", 16'h1, 16'(fault_n_oe));
    chk("regulator", 16'h1, 16'(analog_reg_en));
    chk("hiz early", 16'h0, 16'(hb_enable));
    chk("uv flag", 16'h1, 16'(supply_undervolt));
    cyc(1);
    analog_supply_ok <= 1'b1;
    look(8);
    chk("fault freed", 16'h1, 16'(fault_line));
    chk("uv clear", 16'h0, 16'(supply_undervolt));
    for (n = 0; n < 41000 && !mute_charge; n++) @(negedge mclk);
    chk("precharge", 16'h1, 16'(n > 39900 && n < 40100));
    for (n = 0; n < RAMP + 50 && !mute_node_charged; n++) @(negedge mclk);
    look(8);
    chk("running", 16'hF, 16'(hb_enable));
  endtask
  task automatic t_local;
    cyc(1);
    bootstrap_undervolt <= 4'h4;
    look(8);
    chk("boot uv", 16'hB, 16'(hb_enable));
    chk("boot fault", 16'h1, 16'(fault_line));
    cyc(1);
    bootstrap_undervolt <= 4'h0;
    mode_sel <= 2'h1;
    look(8);
    chk("mono", 16'h3, 16'(hb_enable));
    cyc(1);
    mode_sel <= 2'h0;
    temp_warn <= 1'b1;
    look(8);
    chk("boot back", 16'hF, 16'(hb_enable));
    chk("warn low", 16'h0, 16'(warn_line));
    cyc(1);
    temp_warn <= 1'b0;
    look(8);
    chk("warn off", 16'h1, 16'(warn_line));
  endtask
  task automatic t_flip;
    for (n = 0; n < FRAME + 2 && !frame_start; n++) @(posedge mclk);
    cycle_current_limit <= 2'h1;
    cyc(3);
    cycle_current_limit <= 2'h0;
    look(4);
    chk("flip set", 16'h1, 16'(fb_flip));
    look(11);
    chk("flip clear", 16'h0, 16'(fb_flip));
  endtask
  task automatic t_clip;
    int p1, p2, nw;
    p1 = -1;
    p2 = -1;
    nw = 0;
    cyc(1);
    clip_detect <= 2'h2;
    for (n = 0; n < 12 * FRAME; n++) begin
      @(negedge mclk);
      nw = nw + int'(!warn_line);
      if (pulse_inject[1] === 1'b1 && p1 >= 0 && p2 < 0) p2 = n;
      if (pulse_inject[1] === 1'b1 && p1 < 0) p1 = n;
    end
    chk("inject gap", 16'h40, 16'(p2 - p1));
    chk("clip width", 16'h14, 16'(nw));
    cyc(1);
    clip_detect <= 2'h0;
  endtask
  task automatic t_overload;
    cyc(1);
    cycle_current_limit <= 2'h1;
    for (n = 0; n < 180 * FRAME && hb_enable[1:0] !== 2'h0; n++) @(negedge mclk);
    chk("olp time", 16'h1, 16'(n >= 169 * FRAME && n < 171 * FRAME));
    look(2);
    chk("ch0 off", 16'hC, 16'(hb_enable));
    chk("olp fault", 16'h0, 16'(fault_line));
    cyc(1);
    cycle_current_limit <= 2'h0;
    look(40);
    chk("olp latch", 16'hC, 16'(hb_enable));
    cyc(1);
    dc_imbalance <= 2'h2;
    for (n = 0; n < 260 * FRAME && hb_enable !== 4'h0; n++) @(negedge mclk);
    chk("dc time", 16'h1, 16'(n >= 254 * FRAME && n < 257 * FRAME));
    chk("dc off", 16'h0, 16'(hb_enable));
    cyc(1);
    dc_imbalance <= 2'h0;
  endtask
  task automatic t_mute_reset;
    cyc(1);
    mute_req <= 1'b1;
    look(8);
    chk("mute ramp", 16'h1, 16'(mute_discharge));
    for (n = 0; n < RAMP + 50 && !mute_node_discharged; n++) @(negedge mclk);
    look(4);
    chk("muted hiz", 16'h0, 16'(hb_enable));
    chk("muted live", 16'h2, 16'({analog_reg_en, low_power}));
    cyc(1);
    run_req <= 1'b0;
    look(8);
    chk("fault forced", 16'h1, 16'(fault_line));
    look(RAMP + 20);
    chk("low power", 16'h1, 16'(low_power));
    chk("pull downs", 16'hF, 16'(hb_pulldown));
  endtask
  task automatic t_parallel;
    cyc(1);
    mode_sel <= 2'h2;
    mute_req <= 1'b0;
    cyc(20);
    run_req <= 1'b1;
    for (n = 0; n < 41000 + RAMP && hb_enable !== 4'hF; n++) @(negedge mclk);
    chk("restart", 16'hF, 16'(hb_enable));
    cyc(1);
    cycle_current_limit <= 2'h2;
    for (n = 0; n < 180 * FRAME && hb_enable !== 4'h0; n++) @(negedge mclk);
    look(2);
    chk("all off", 16'h0, 16'(hb_enable));
    cyc(1);
    cycle_current_limit <= 2'h0;
    temp_shutdown <= 1'b1;
    look(8);
    chk("ote flag", 16'h1, 16'(thermal_shutdown));
    chk("ote fault", 16'h0, 16'(fault_line));
    cyc(1);
    temp_shutdown <= 1'b0;
    look(40);
    chk("ote latch", 16'h1, 16'(thermal_shutdown));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    cyc(4);
    t_startup();
    t_local();
    t_flip();
    t_clip();
    t_overload();
    t_mute_reset();
    t_parallel();
    stop_test();
  end
endmodule
`default_nettype wire
